/* nbs_map.vh */
`ifndef NBS_MAP_VH
`define NBS_MAP_VH

// register offsets (byte address, low eight bits)
`define NBS_OFF_CTRL 8'h00
`define NBS_OFF_CFG 8'h04
`define NBS_OFF_ADDR_LO 8'h08
`define NBS_OFF_ADDR_HI 8'h0c
`define NBS_OFF_COUNT 8'h10
`define NBS_OFF_DATA 8'h14
`define NBS_OFF_STATUS 8'h18

// control and config word fields
`define NBS_CTRL_OP_MSB 3
`define NBS_CTRL_HOLD 4
`define NBS_CTRL_PLANE 5
`define NBS_CFG_X16 0
`define NBS_CFG_UNPROT 1

// status word fields
`define NBS_ST_BUSY 0
`define NBS_ST_RDV 1
`define NBS_ST_WRF 2
`define NBS_ST_REF 3
`define NBS_ST_RDY 4
`define NBS_ST_SLOW 5
`define NBS_ST_RMODE 6
`define NBS_ST_SB_LSB 8

// reset values
`define NBS_CFG_RST 2'h0
`define NBS_COUNT_RST 12'h000

// operation codes written to the control word
`define NBS_OP_READ 4'h0
`define NBS_OP_CSEQ 4'h1
`define NBS_OP_CRND 4'h2
`define NBS_OP_CEND 4'h3
`define NBS_OP_ROUT 4'h4
`define NBS_OP_PROG 4'h5
`define NBS_OP_RIN 4'h6
`define NBS_OP_PLN2 4'h7
`define NBS_OP_STAT 4'h8
`define NBS_OP_RESET 4'h9

// flash command bytes
`define NBS_CMD_READ 8'h00
`define NBS_CMD_READ_GO 8'h30
`define NBS_CMD_CACHE 8'h31
`define NBS_CMD_CACHE_END 8'h3f
`define NBS_CMD_ROUT 8'h05
`define NBS_CMD_ROUT_GO 8'he0
`define NBS_CMD_LOAD 8'h80
`define NBS_CMD_LOAD2 8'h81
`define NBS_CMD_RIN 8'h85
`define NBS_CMD_PROG_GO 8'h10
`define NBS_CMD_DUMMY_GO 8'h11
`define NBS_CMD_STATUS 8'h70
`define NBS_CMD_RESET 8'hff

// address cycles and page geometry
`define NBS_ACYC_FULL 3'h5
`define NBS_ACYC_COL 3'h2
`define NBS_LAST_ROW 18'h3ffff

// pin cycle kinds
`define NBS_K_CMD 2'h0
`define NBS_K_ADDR 2'h1
`define NBS_K_DIN 2'h2
`define NBS_K_DOUT 2'h3

// timing
`define NBS_CLK_MHZ 10
`define NBS_PHASE_NS 100
`define NBS_PHASE_CYC ((`NBS_PHASE_NS * `NBS_CLK_MHZ + 999) / 1000)
`define NBS_TWB_NS 100
`define NBS_TWB_CYC ((`NBS_TWB_NS * `NBS_CLK_MHZ + 999) / 1000)
`define NBS_TR_US 25
`define NBS_TR_CYC (`NBS_TR_US * `NBS_CLK_MHZ)

`endif

/* nbs_pincyc.v */
`include "nbs_map.vh"

module nbs_pincyc (
  // system
  input wire clk,
  input wire rst,
  // request
  input wire go,
  input wire [1:0] kind,
  input wire [15:0] wdata,
  input wire x16,
  input wire sel,
  output reg done,
  output reg busy,
  output reg [15:0] rdata,
  // flash pins
  output reg ce_n,
  output reg cle,
  output reg ale,
  output reg we_n,
  output reg re_n,
  output reg [15:0] io_out,
  output reg io_oe,
  input wire [15:0] io_in
);

  localparam [3:0] P_IDLE = 4'h1;
  localparam [3:0] P_SET = 4'h2;
  localparam [3:0] P_LOW = 4'h4;
  localparam [3:0] P_HIGH = 4'h8;
  localparam integer PH_CYC_I = `NBS_PHASE_CYC;
  localparam [7:0] PH_CYC = PH_CYC_I[7:0];

  reg [3:0] ph;
  reg [7:0] div;
  reg rd;
  wire tick = (div == 8'h00);

  // phase divider, restarted by each request so every phase is full width
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 8'h00;
    end else if (go || tick) begin
      div <= PH_CYC - 8'h01;
    end else begin
      div <= div - 8'h01;
    end
  end

  // one bus cycle: setup, strobe low, strobe high (hold)
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ph <= P_IDLE;
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      re_n <= 1'b1;
      io_out <= 16'h0000;
      io_oe <= 1'b0;
      rdata <= 16'h0000;
      done <= 1'b0;
      busy <= 1'b0;
      rd <= 1'b0;
    end else begin
      ce_n <= ~sel;
      done <= 1'b0;
      case (ph)
        P_IDLE: begin
          if (go) begin
            busy <= 1'b1;
            rd <= (kind == `NBS_K_DOUT);
            cle <= (kind == `NBS_K_CMD);
            ale <= (kind == `NBS_K_ADDR);
            // commands and addresses always on the low byte lane
            io_out <= (kind == `NBS_K_DIN && x16) ? wdata : {8'h00, wdata[7:0]};
            io_oe <= (kind != `NBS_K_DOUT);
            ph <= P_SET;
          end
        end
        P_SET: begin
          if (tick) begin
            we_n <= rd;
            re_n <= ~rd;
            ph <= P_LOW;
          end
        end
        P_LOW: begin
          if (tick) begin
            we_n <= 1'b1;
            re_n <= 1'b1;
            // sampled while the read strobe is still low
            if (rd) begin
              rdata <= x16 ? io_in : {8'h00, io_in[7:0]};
            end
            ph <= P_HIGH;
          end
        end
        P_HIGH: begin
          if (tick) begin
            cle <= 1'b0;
            ale <= 1'b0;
            io_oe <= 1'b0;
            done <= 1'b1;
            busy <= 1'b0;
            ph <= P_IDLE;
          end
        end
        default: begin
          ph <= P_IDLE;
        end
      endcase
    end
  end

endmodule

/* nbs_ctrl.v */
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`include "nbs_map.vh"

// Behaviour
// RULE1 - command byte with command latch, low lane
// RULE2 - address byte with address latch, low lane
// RULE3 - guard pin high through program sequences (code returns it to the cfg unprotect bit in idle between held operations)
// RULE4 - program words clocked by write strobe
// RULE5 - output words clocked by read strobe
// RULE6 - guard low blocks all array changes
// RULE7 - deselected flash ignores bus, outputs off
// RULE8 - flash powers up in read mode
// RULE9 - read setup, five addresses, confirm, busy
// RULE10 - page streams out from chosen column
// RULE11 - random output moves the output column
// RULE12 - other commands leave read mode
// RULE13 - cache read only after finished page read
// RULE14 - cache read returns previous page, column zero
// RULE15 - cache end copies final page out
// RULE16 - no sequential cache after last page
// RULE17 - program: load, addresses, data, confirm
// RULE18 - random input moves the input column
// RULE19 - only status or reset while programming
// RULE20 - status mode persists after program
// RULE21 - two-plane: dummy confirm, second load, confirm
// RULE22 - status read allowed during dummy busy (code waits in S_WAIT for ready, refusing all starts)
// RULE23 - wait ready before next non-status command
module nbs_ctrl (
  // system
  input wire CORE_CLK,
  input wire RST,
  // ahb-lite slave
  input wire HSEL,
  input wire [31:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // flash pins
  output wire CHIP_SEL_N,
  output wire CMD_LATCH,
  output wire ADDR_LATCH,
  output wire WRITE_STROBE_N,
  output wire READ_STROBE_N,
  output reg WRITE_GUARD_N,
  output wire [15:0] IO_OUT,
  output wire IO_OE,
  input wire [15:0] IO_IN,
  input wire READY_BUSY_OUTPUT_N
);

  localparam [9:0] S_IDLE = 10'h001;
  localparam [9:0] S_CMD1 = 10'h002;
  localparam [9:0] S_ADDR = 10'h004;
  localparam [9:0] S_DIN = 10'h008;
  localparam [9:0] S_CMD2 = 10'h010;
  localparam [9:0] S_TWB = 10'h020;
  localparam [9:0] S_WAIT = 10'h040;
  localparam [9:0] S_DOUT = 10'h080;
  localparam [9:0] S_STAT = 10'h100;
  localparam [9:0] S_SREAD = 10'h200;
  localparam integer TWB_CYC_I = `NBS_TWB_CYC;
  localparam integer TR_CYC_I = `NBS_TR_CYC;
  localparam [7:0] TWB_CYC = TWB_CYC_I[7:0];
  localparam [8:0] TR_CYC = TR_CYC_I[8:0];

  // registers seen by software
  reg [1:0] cfg;
  reg [31:0] addr_lo;
  reg [7:0] addr_hi;
  reg [11:0] count;
  reg [15:0] wr_word;
  reg wr_full;
  reg [15:0] rd_word;
  reg rd_valid;
  reg refused;
  reg slow;
  reg [7:0] status_byte;
  // bus pipeline
  reg wr_pend;
  reg [7:0] wr_addr;
  // sequencer
  reg [9:0] state;
  reg [3:0] op;
  reg hold;
  reg plane;
  reg [11:0] cnt;
  reg [2:0] aidx;
  reg issued;
  reg pc_go;
  reg [1:0] pc_kind;
  reg [15:0] pc_wdata;
  reg read_mode;
  reg load_open;
  reg plane_open;
  reg [17:0] cache_row;
  reg [7:0] wb_cnt;
  reg [8:0] busy_cnt;
  wire pc_done;
  wire pc_busy;
  wire [15:0] pc_rdata;

  // picks one address cycle byte, first cycle at index zero
  function [7:0] addr_byte;
    input [2:0] idx;
    input [39:0] a;
    begin
      case (idx)
        3'h0: addr_byte = a[7:0];
        3'h1: addr_byte = a[15:8];
        3'h2: addr_byte = a[23:16];
        3'h3: addr_byte = a[31:24];
        default: addr_byte = a[39:32];
      endcase
    end
  endfunction

  // true for operations that modify the array
  function is_prog;
    input [3:0] o;
    begin
      is_prog = (o == `NBS_OP_PROG) || (o == `NBS_OP_RIN) || (o == `NBS_OP_PLN2);
    end
  endfunction

  // operation decode: first command, address cycles, direction, confirm, wait
  reg [7:0] c1;
  reg [2:0] na;
  reg d_in;
  reg d_out;
  reg [7:0] c2;
  reg h2;
  reg wt;
  always @* begin
    c1 = `NBS_CMD_RESET;
    na = 3'h0;
    d_in = 1'b0;
    d_out = 1'b0;
    c2 = plane ? `NBS_CMD_DUMMY_GO : `NBS_CMD_PROG_GO;
    h2 = 1'b0;
    wt = 1'b1;
    case (op)
      // RULE9 - read setup and confirm
      `NBS_OP_READ: begin c1 = `NBS_CMD_READ; na = `NBS_ACYC_FULL; d_out = 1'b1; c2 = `NBS_CMD_READ_GO; h2 = 1'b1; end
      `NBS_OP_CSEQ: begin c1 = `NBS_CMD_CACHE; d_out = 1'b1; end
      `NBS_OP_CRND: begin c1 = `NBS_CMD_READ; na = `NBS_ACYC_FULL; d_out = 1'b1; c2 = `NBS_CMD_CACHE; h2 = 1'b1; end
      `NBS_OP_CEND: begin c1 = `NBS_CMD_CACHE_END; d_out = 1'b1; end
      `NBS_OP_ROUT: begin c1 = `NBS_CMD_ROUT; na = `NBS_ACYC_COL; d_out = 1'b1; c2 = `NBS_CMD_ROUT_GO; h2 = 1'b1; wt = 1'b0; end
      // RULE17 - load, addresses, data, confirm
      `NBS_OP_PROG: begin c1 = `NBS_CMD_LOAD; na = `NBS_ACYC_FULL; d_in = 1'b1; h2 = ~hold; wt = ~hold; end
      `NBS_OP_RIN: begin c1 = `NBS_CMD_RIN; na = `NBS_ACYC_COL; d_in = 1'b1; h2 = ~hold; wt = ~hold; end
      // RULE21 - second plane load
      `NBS_OP_PLN2: begin c1 = `NBS_CMD_LOAD2; na = `NBS_ACYC_FULL; d_in = 1'b1; c2 = `NBS_CMD_PROG_GO; h2 = 1'b1; end
      `NBS_OP_STAT: begin c1 = `NBS_CMD_STATUS; wt = 1'b0; end
      default: begin c1 = `NBS_CMD_RESET; end
    endcase
  end

  wire cnt_nz = (count != 12'h000);
  wire ready = READY_BUSY_OUTPUT_N;
  wire prog_conf = d_in && h2 && (c2 == `NBS_CMD_PROG_GO);
  wire [9:0] st_after_wait = (op == `NBS_OP_STAT) ? S_SREAD : (d_out && cnt_nz) ? S_DOUT :
                             prog_conf ? S_STAT : S_IDLE;
  wire [9:0] st_after_din = h2 ? S_CMD2 : wt ? S_TWB : st_after_wait;
  wire [9:0] st_after_addr = (d_in && cnt_nz) ? S_DIN : st_after_din;
  wire [9:0] st_after_cmd1 = (na != 3'h0) ? S_ADDR : st_after_addr;

  // start checks on a write to the control word
  wire [3:0] new_op = HWDATA[`NBS_CTRL_OP_MSB:0];
  wire start_req = wr_pend && (wr_addr == `NBS_OFF_CTRL);
  wire [17:0] req_row = {addr_hi[1:0], addr_lo[31:16]};
  reg start_ok;
  always @* begin
    // RULE23 - only status or reset while busy
    // RULE19 - same limit holds during programming
    start_ok = (state == S_IDLE) && (ready || new_op == `NBS_OP_STAT || new_op == `NBS_OP_RESET);
    case (new_op)
      // RULE13 - cache only after a finished read
      `NBS_OP_CRND: start_ok = start_ok && read_mode;
      // RULE16 - stop at the last page
      `NBS_OP_CSEQ: start_ok = start_ok && read_mode && (cache_row != `NBS_LAST_ROW);
      `NBS_OP_CEND: start_ok = start_ok && read_mode;
      // RULE11 - reposition only inside a loaded page
      `NBS_OP_ROUT: start_ok = start_ok && read_mode;
      // RULE18 - random input only while a load is open
      `NBS_OP_RIN: start_ok = start_ok && load_open;
      // RULE21 - second plane only after dummy confirm
      `NBS_OP_PLN2: start_ok = start_ok && plane_open;
      `NBS_OP_STAT, `NBS_OP_RESET, `NBS_OP_READ, `NBS_OP_PROG: start_ok = start_ok;
      default: start_ok = 1'b0;
    endcase
  end

  wire seq_take = (state == S_DIN) && pc_done;
  wire seq_give = (state == S_DOUT) && pc_done;
  wire rd_acc = HSEL && HTRANS[1] && HREADY && !HWRITE;
  wire pop = rd_acc && (HADDR[7:0] == `NBS_OFF_DATA);
  wire push = wr_pend && (wr_addr == `NBS_OFF_DATA);

  // read mux, sampled at the address phase so hrdata is a flop
  reg [31:0] rd_mux;
  always @* begin
    case (HADDR[7:0])
      `NBS_OFF_CFG: rd_mux = {30'h00000000, cfg};
      `NBS_OFF_ADDR_LO: rd_mux = addr_lo;
      `NBS_OFF_ADDR_HI: rd_mux = {24'h000000, addr_hi};
      `NBS_OFF_COUNT: rd_mux = {20'h00000, count};
      `NBS_OFF_DATA: rd_mux = {16'h0000, rd_word};
      `NBS_OFF_STATUS: rd_mux = {16'h0000, status_byte, 1'b0, read_mode, slow, ready,
                                 refused, wr_full, rd_valid, (state != S_IDLE)};
      `NBS_OFF_CTRL: rd_mux = {26'h0000000, plane, hold, op};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // ahb-lite slave: zero wait states, always okay
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      cfg <= `NBS_CFG_RST;
      addr_lo <= 32'h00000000;
      addr_hi <= 8'h00;
      count <= `NBS_COUNT_RST;
      wr_word <= 16'h0000;
      wr_full <= 1'b0;
      rd_valid <= 1'b0;
    end else begin
      wr_pend <= HSEL && HTRANS[1] && HREADY && HWRITE;
      wr_addr <= HADDR[7:0];
      if (rd_acc) begin
        HRDATA <= rd_mux;
      end
      if (wr_pend) begin
        case (wr_addr)
          `NBS_OFF_CFG: cfg <= HWDATA[1:0];
          `NBS_OFF_ADDR_LO: addr_lo <= HWDATA;
          `NBS_OFF_ADDR_HI: addr_hi <= HWDATA[7:0];
          `NBS_OFF_COUNT: count <= HWDATA[11:0];
          `NBS_OFF_DATA: wr_word <= HWDATA[15:0];
          default: wr_addr <= wr_addr;
        endcase
      end
      // software fill wins over a take in the same cycle
      wr_full <= (wr_full && !seq_take) || push;
      // a new word wins over a pop in the same cycle
      rd_valid <= (rd_valid && !pop) || seq_give;
    end
  end

  // sequencer
  always @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      state <= S_IDLE;
      op <= `NBS_OP_READ;
      hold <= 1'b0;
      plane <= 1'b0;
      cnt <= 12'h000;
      aidx <= 3'h0;
      issued <= 1'b0;
      pc_go <= 1'b0;
      pc_kind <= `NBS_K_CMD;
      pc_wdata <= 16'h0000;
      refused <= 1'b0;
      slow <= 1'b0;
      status_byte <= 8'h00;
      rd_word <= 16'h0000;
      // RULE8 - flash starts in read mode, but no page is loaded
      read_mode <= 1'b0;
      load_open <= 1'b0;
      plane_open <= 1'b0;
      cache_row <= 18'h00000;
      wb_cnt <= 8'h00;
      busy_cnt <= 9'h000;
      WRITE_GUARD_N <= 1'b0;
    end else begin
      pc_go <= 1'b0;
      case (state)
        S_IDLE: begin
          WRITE_GUARD_N <= cfg[`NBS_CFG_UNPROT];
          if (start_req && !start_ok) begin
            refused <= 1'b1;
          end
          if (start_req && start_ok) begin
            refused <= 1'b0;
            op <= new_op;
            hold <= HWDATA[`NBS_CTRL_HOLD];
            plane <= HWDATA[`NBS_CTRL_PLANE];
            // RULE3 - guard released for each program operation, back to the cfg unprotect bit once idle
            WRITE_GUARD_N <= is_prog(new_op) | cfg[`NBS_CFG_UNPROT];
            // RULE12 - anything but read, sequential or random cache read, or random output leaves read mode
            read_mode <= (new_op == `NBS_OP_READ) || (new_op == `NBS_OP_CSEQ) ||
                         (new_op == `NBS_OP_CRND) || (new_op == `NBS_OP_ROUT);
            load_open <= is_prog(new_op) && HWDATA[`NBS_CTRL_HOLD] && (new_op != `NBS_OP_PLN2);
            plane_open <= (new_op == `NBS_OP_PROG || new_op == `NBS_OP_RIN) &&
                          HWDATA[`NBS_CTRL_PLANE] && !HWDATA[`NBS_CTRL_HOLD];
            if (new_op == `NBS_OP_READ || new_op == `NBS_OP_CRND) begin
              cache_row <= req_row;
            end else if (new_op == `NBS_OP_CSEQ) begin
              cache_row <= cache_row + 18'h00001;
            end
            slow <= 1'b0;
            state <= S_CMD1;
          end
        end
        // RULE1 - command cycle
        S_CMD1, S_CMD2, S_STAT: begin
          if (!issued && !pc_busy) begin
            pc_go <= 1'b1;
            issued <= 1'b1;
            pc_kind <= `NBS_K_CMD;
            pc_wdata <= {8'h00, (state == S_CMD1) ? c1 : (state == S_CMD2) ? c2 : `NBS_CMD_STATUS};
          end
          if (pc_done) begin
            issued <= 1'b0;
            aidx <= 3'h0;
            cnt <= count;
            wb_cnt <= 8'h00;
            if (state == S_CMD1) begin
              state <= st_after_cmd1;
            end else if (state == S_CMD2) begin
              state <= wt ? S_TWB : st_after_wait;
            end else begin
              state <= S_SREAD;
            end
          end
        end
        // RULE2 - address cycles
        S_ADDR: begin
          if (!issued && !pc_busy) begin
            pc_go <= 1'b1;
            issued <= 1'b1;
            pc_kind <= `NBS_K_ADDR;
            pc_wdata <= {8'h00, addr_byte(aidx, {addr_hi, addr_lo})};
          end
          if (pc_done) begin
            issued <= 1'b0;
            aidx <= aidx + 3'h1;
            if (aidx + 3'h1 == na) begin
              state <= st_after_addr;
            end
          end
        end
        // RULE4 - one word per write strobe, paced by software
        S_DIN: begin
          if (!issued && !pc_busy && wr_full) begin
            pc_go <= 1'b1;
            issued <= 1'b1;
            pc_kind <= `NBS_K_DIN;
            pc_wdata <= wr_word;
          end
          if (pc_done) begin
            issued <= 1'b0;
            cnt <= cnt - 12'h001;
            if (cnt == 12'h001) begin
              state <= st_after_din;
            end
          end
        end
        // busy edge appears only after the strobe-to-busy delay
        S_TWB: begin
          wb_cnt <= wb_cnt + 8'h01;
          busy_cnt <= 9'h000;
          if (wb_cnt >= TWB_CYC) begin
            state <= S_WAIT;
          end
        end
        // RULE23 - hold until the flash is ready
        S_WAIT: begin
          if (busy_cnt != TR_CYC) begin
            busy_cnt <= busy_cnt + 9'h001;
          end else if (d_out) begin
            slow <= 1'b1;
          end
          if (ready) begin
            state <= st_after_wait;
          end
        end
        // RULE5 - one word per read strobe, paced by software
        S_DOUT: begin
          if (!issued && !pc_busy && !rd_valid) begin
            pc_go <= 1'b1;
            issued <= 1'b1;
            pc_kind <= `NBS_K_DOUT;
          end
          if (pc_done) begin
            issued <= 1'b0;
            rd_word <= pc_rdata;
            cnt <= cnt - 12'h001;
            if (cnt == 12'h001) begin
              state <= S_IDLE;
            end
          end
        end
        // RULE20 - status read after program completes
        S_SREAD: begin
          if (!issued && !pc_busy) begin
            pc_go <= 1'b1;
            issued <= 1'b1;
            pc_kind <= `NBS_K_DOUT;
          end
          if (pc_done) begin
            issued <= 1'b0;
            status_byte <= pc_rdata[7:0];
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // pin cycle engine; chip select held through the whole operation
  nbs_pincyc u_pin (
    .clk(CORE_CLK),
    .rst(RST),
    .go(pc_go),
    .kind(pc_kind),
    .wdata(pc_wdata),
    .x16(cfg[`NBS_CFG_X16]),
    .sel(state != S_IDLE),
    .done(pc_done),
    .busy(pc_busy),
    .rdata(pc_rdata),
    .ce_n(CHIP_SEL_N),
    .cle(CMD_LATCH),
    .ale(ADDR_LATCH),
    .we_n(WRITE_STROBE_N),
    .re_n(READ_STROBE_N),
    .io_out(IO_OUT),
    .io_oe(IO_OE),
    .io_in(IO_IN)
  );

endmodule

/* nbs_sva.sv */
module nbs_sva (
  // clock and bus answer
  input wire CORE_CLK,
  input wire RST,
  input wire HREADYOUT,
  input wire HRESP,
  // flash pins
  input wire CHIP_SEL_N,
  input wire CMD_LATCH,
  input wire ADDR_LATCH,
  input wire WRITE_STROBE_N,
  input wire READ_STROBE_N,
  input wire WRITE_GUARD_N,
  input wire [15:0] IO_OUT,
  input wire IO_OE
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  // strobe low then high, one phase each
  sequence s_wpulse;
    $fell(WRITE_STROBE_N) ##1 $rose(WRITE_STROBE_N);
  endsequence
  // read confirm on the command lane
  sequence s_confirm;
    CMD_LATCH && !WRITE_STROBE_N && IO_OUT[7:0] == 8'h30;
  endsequence
  AST_BUS: assert property (HREADYOUT && !HRESP) else $error("bus answer not ready");
  AST_CMD: assert property (CMD_LATCH && !WRITE_STROBE_N |-> !ADDR_LATCH && READ_STROBE_N && !CHIP_SEL_N && IO_OE)
    else $error("bad command cycle");
  AST_ADR: assert property (ADDR_LATCH && !WRITE_STROBE_N |-> !CMD_LATCH && READ_STROBE_N && !CHIP_SEL_N && IO_OE)
    else $error("bad address cycle");
  AST_DIN: assert property (!CMD_LATCH && !ADDR_LATCH && !WRITE_STROBE_N |-> WRITE_GUARD_N && READ_STROBE_N && IO_OE)
    else $error("bad data input cycle");
  AST_DOUT: assert property (!READ_STROBE_N |-> WRITE_STROBE_N && !CMD_LATCH && !ADDR_LATCH && !CHIP_SEL_N && !IO_OE)
    else $error("bad data output cycle");
  AST_RPULSE: assert property ($fell(READ_STROBE_N) |=> $rose(READ_STROBE_N))
    else $error("read strobe width");
  AST_WPULSE: assert property ($fell(WRITE_STROBE_N) |-> s_wpulse)
    else $error("write strobe width");
  AST_HOLD: assert property (s_wpulse |-> $stable(IO_OUT) && $stable(CMD_LATCH) && $stable(ADDR_LATCH))
    else $error("lane moved under strobe");
  AST_GUARD: assert property (CMD_LATCH && !WRITE_STROBE_N &&
    IO_OUT[7:0] inside {8'h80, 8'h81, 8'h85, 8'h10, 8'h11} |-> WRITE_GUARD_N) else $error("guard low in program");
  AST_WAIT: assert property (s_confirm ##1 WRITE_STROBE_N |=> (WRITE_STROBE_N && READ_STROBE_N) [*2])
    else $error("strobe too soon after confirm");
endmodule

bind nbs_ctrl nbs_sva u_sva (.CORE_CLK(CORE_CLK), .RST(RST), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
  .CHIP_SEL_N(CHIP_SEL_N), .CMD_LATCH(CMD_LATCH), .ADDR_LATCH(ADDR_LATCH), .WRITE_STROBE_N(WRITE_STROBE_N),
  .READ_STROBE_N(READ_STROBE_N), .WRITE_GUARD_N(WRITE_GUARD_N), .IO_OUT(IO_OUT), .IO_OE(IO_OE));

/* nbs_flash.sv */
module nbs_flash #(
  parameter int BUSY_NS = 3000
) (
  // strobes
  input wire cs_n,
  input wire cle,
  input wire ale,
  input wire we_n,
  input wire re_n,
  input wire wp_n,
  // bus and ready
  input wire [15:0] io,
  output logic [15:0] dout,
  output logic rb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // page store is short, column wraps at 64
  logic [15:0] mem [64];
  logic [5:0] col;
  logic [2:0] na;
  logic st;
  initial begin
    rb_n = 1;
    dout = 0;
    col = 0;
    na = 0;
    st = 0;
  end
  task automatic busy;
    fork
      begin
        rb_n = 0;
        #BUSY_NS rb_n = 1;
      end
    join_none
  endtask
  always @(posedge we_n) begin
    if (!cs_n && cle && !ale) begin
      na = 0;
      st = io[7:0] == 8'h70;
      if (io[7:0] inside {8'h31, 8'h3f})
        col = 0;
      if (io[7:0] inside {8'h30, 8'h31, 8'h3f, 8'hff} || (io[7:0] inside {8'h10, 8'h11} && wp_n))
        busy();
    end else if (!cs_n && ale && !cle) begin
      if (na == 0)
        col = io[5:0];
      na = na + 3'h1;
    end else if (!cs_n && !cle && !ale && wp_n) begin
      mem[col] = io;
      col = col + 6'h1;
    end
  end
  always @(negedge re_n) begin
    if (!cs_n) begin
      dout = st ? {9'h0, rb_n, 6'h0} : mem[col];
      col = st ? col : col + 6'h1;
    end
  end
  // released bus shows no stale word
  always @(posedge re_n or posedge cs_n) #20 dout = ~dout;
endmodule

/* testbench.sv */
`include "nbs_map.vh"

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic CORE_CLK = 0;
  logic RST = 1;
  logic HSEL = 0;
  logic HWRITE = 0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0;
  logic [31:0] HWDATA = 32'h0;
  wire [31:0] HRDATA;
  wire HREADYOUT, HRESP, cs_n, cle, ale, we_n, re_n, wp_n, oe, rb_n;
  wire [15:0] io_out, m_out;
  // bus level from both parties
  wire [15:0] io = oe ? io_out : m_out;
  int bad_count = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [31:0] v;
  logic [15:0] pat [4] = '{16'h0f0f, 16'ha5c3, 16'h1234, 16'hfedc};

  nbs_ctrl u_dut (.CORE_CLK(CORE_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .CHIP_SEL_N(cs_n), .CMD_LATCH(cle), .ADDR_LATCH(ale),
    .WRITE_STROBE_N(we_n), .READ_STROBE_N(re_n), .WRITE_GUARD_N(wp_n), .IO_OUT(io_out),
    .IO_OE(oe), .IO_IN(io), .READY_BUSY_OUTPUT_N(rb_n));
  nbs_flash u_flash (.cs_n(cs_n), .cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io(io), .dout(m_out), .rb_n(rb_n));

  initial forever #50 CORE_CLK = ~CORE_CLK;
  // hang guard, well above the expected run
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      summarize();
    end
  end

  task automatic summarize;
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single transfer, read data taken at data edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {24'h0, a};
    HWRITE <= wr;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CORE_CLK); while (HREADYOUT !== 1'b1);
    v = HRDATA;
  endtask
  task automatic st_wait(input int n, input logic b);
    do xfer(1'b0, `NBS_OFF_STATUS, 32'h0); while (v[n] !== b);
  endtask
  task automatic go(input logic [31:0] c, input logic [31:0] a, input logic [11:0] n);
    st_wait(`NBS_ST_BUSY, 1'b0);
    xfer(1'b1, `NBS_OFF_ADDR_LO, a);
    xfer(1'b1, `NBS_OFF_COUNT, {20'h0, n});
    xfer(1'b1, `NBS_OFF_CTRL, c);
    @(posedge CORE_CLK);
  endtask
  task automatic put(input logic [15:0] d);
    st_wait(`NBS_ST_WRF, 1'b0);
    xfer(1'b1, `NBS_OFF_DATA, {16'h0, d});
  endtask
  task automatic get(input logic [15:0] e);
    st_wait(`NBS_ST_RDV, 1'b1);
    xfer(1'b0, `NBS_OFF_DATA, 32'h0);
    chk(v, {16'h0, e});
  endtask

  initial begin
    repeat (8) @(posedge CORE_CLK);
    RST <= 1'b0;
    xfer(1'b0, `NBS_OFF_CFG, 32'h0);
    chk(v, {30'h0, `NBS_CFG_RST});
    // unmapped place reads zero, write dropped
    xfer(1'b1, 8'h40, 32'hffff);
    xfer(1'b0, 8'h40, 32'h0);
    chk(v, 32'h0);
    xfer(1'b1, `NBS_OFF_CFG, 32'h1);
    xfer(1'b1, `NBS_OFF_ADDR_HI, 32'h0);
    // program held open (0x15), then random input closes it
    go(32'h15, 32'h0, 12'h2);
    put(pat[0]);
    put(pat[1]);
    go({28'h0, `NBS_OP_RIN}, 32'h2, 12'h2);
    put(pat[2]);
    put(pat[3]);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'hff4f, 32'h4000);
    go({28'h0, `NBS_OP_ROUT}, 32'h0, 12'h1);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'h8, 32'h8);
    go({28'h0, `NBS_OP_READ}, 32'h0, 12'h4);
    for (int i = 0; i < 4; i++)
      get(pat[i]);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'h48, 32'h40);
    go({28'h0, `NBS_OP_ROUT}, 32'h3, 12'h1);
    get(pat[3]);
    go({28'h0, `NBS_OP_CSEQ}, 32'h0, 12'h1);
    get(pat[0]);
    go({28'h0, `NBS_OP_CRND}, 32'h0, 12'h1);
    get(pat[0]);
    go({28'h0, `NBS_OP_CEND}, 32'h0, 12'h1);
    get(pat[0]);
    // last row of the device: sequential cache refused
    xfer(1'b1, `NBS_OFF_ADDR_HI, 32'h3);
    go({28'h0, `NBS_OP_READ}, 32'hffff0000, 12'h1);
    get(pat[0]);
    go({28'h0, `NBS_OP_CSEQ}, 32'hffff0000, 12'h1);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'h8, 32'h8);
    xfer(1'b1, `NBS_OFF_ADDR_HI, 32'h0);
    // two planes: plane bit set (0x25) gives the dummy confirm
    go(32'h25, 32'h0, 12'h1);
    put(16'h5a5a);
    go({28'h0, `NBS_OP_PLN2}, 32'h0, 12'h1);
    put(16'h3c3c);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'hff08, 32'h4000);
    go({28'h0, `NBS_OP_STAT}, 32'h0, 12'h0);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'hff08, 32'h4000);
    go({28'h0, `NBS_OP_RESET}, 32'h0, 12'h0);
    st_wait(`NBS_ST_BUSY, 1'b0);
    chk(v & 32'h19, 32'h10);
    // byte-wide bus: upper lane reads zero
    xfer(1'b1, `NBS_OFF_CFG, 32'h0);
    go({28'h0, `NBS_OP_READ}, 32'h0, 12'h1);
    get(16'h003c);
    summarize();
  end
endmodule
